// [hw/dssl_pkg.sv]
// dssl_pkg: constants, types and helpers of the drive serial link block
// assumes one clock; every cycle count is derived from the clock rate
package dssl_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned TENTHS_PER_S   = 10;
  localparam int unsigned BAUD [6]       = '{1200, 2400, 4800, 9600, 19200, 38400};
  localparam int unsigned GAP_HALF_CHARS = 7;
  localparam logic [3:0]  FRAME_OVERHEAD = 4'h3;
  localparam logic [3:0]  DATA7_LAST     = 4'h6;
  localparam logic [3:0]  DATA8_LAST     = 4'h7;
  localparam logic [7:0]  DATA7_MASK     = 8'h7f;
  localparam logic [7:0]  DATA8_MASK     = 8'hff;
  localparam logic [3:0]  HEX_LETTER_ADJ = 4'h9;

  localparam logic [7:0]  ADDR_MASTER = 8'h00;
  localparam logic [7:0]  ADDR_MAX    = 8'hf7;
  localparam logic [7:0]  ADDR_RST    = 8'h01;
  localparam logic [2:0]  RATE_MAX    = 3'h5;
  localparam logic [2:0]  RATE_RST    = 3'h3;
  localparam logic [4:0]  FMT_MAX     = 5'h11;
  localparam logic [4:0]  FMT_RST     = 5'h00;
  localparam logic [4:0]  FMT_ASCII7  = 5'h06;
  localparam logic [4:0]  FMT_ASCII8  = 5'h0c;
  localparam logic [4:0]  FMT_STOP2   = 5'h03;
  localparam logic [7:0]  DELAY_MAX   = 8'hc8;
  localparam logic [7:0]  DELAY_RST   = 8'h05;
  localparam logic [9:0]  TMO_MAX     = 10'h3e8;
  localparam logic [9:0]  TMO_RST     = 10'h000;
  localparam logic [1:0]  ACT_ALARM   = 2'h0;
  localparam logic [1:0]  ACT_KEEP    = 2'h1;
  localparam logic [1:0]  ACT_STOP    = 2'h2;
  localparam logic [1:0]  STOPM_RST   = 2'h0;
  localparam logic [7:0]  FAULT_CODE  = 8'h0f;
  localparam logic [7:0]  ASCII_START = 8'h3a;
  localparam logic [7:0]  ASCII_END   = 8'h0a;
  localparam logic [1:0]  FIDX_HI     = 2'h0;
  localparam logic [1:0]  FIDX_DONE   = 2'h2;

  localparam logic [7:0]  OFF_ADDR    = 8'h00;
  localparam logic [7:0]  OFF_RATE    = 8'h04;
  localparam logic [7:0]  OFF_FMT     = 8'h08;
  localparam logic [7:0]  OFF_DELAY   = 8'h0c;
  localparam logic [7:0]  OFF_TMO     = 8'h10;
  localparam logic [7:0]  OFF_ACT     = 8'h14;
  localparam logic [7:0]  OFF_WRREPLY = 8'h18;
  localparam logic [7:0]  OFF_STOPM   = 8'h1c;
  localparam logic [7:0]  OFF_STATUS  = 8'h20;
  localparam logic [7:0]  OFF_MASK    = 8'h24;
  localparam logic [7:0]  OFF_STATE   = 8'h28;
  localparam int unsigned ST_W        = 3;
  localparam int unsigned STATE_FAULT = 8;
  localparam int unsigned STATE_MSTR  = 9;

  localparam logic [1:0]  PAR_NONE = 2'h0;
  localparam logic [1:0]  PAR_EVEN = 2'h1;
  localparam logic [1:0]  PAR_ODD  = 2'h2;

  typedef struct packed {
    logic       ascii;
    logic       data7;
    logic [1:0] parity;
    logic       stop2;
  } dssl_fmt_s;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_DATA  = 3'b011,
    S_PAR   = 3'b010,
    S_STOP  = 3'b110
  } dssl_uart_e;

  function automatic dssl_fmt_s decodeFmt(input logic [4:0] code);
    logic [4:0] idx;
    dssl_fmt_s  f;
    idx     = code;
    f.ascii = 1'b0;
    f.data7 = 1'b0;
    if (code >= FMT_ASCII8)
    begin
      idx     = code - FMT_ASCII8;
      f.ascii = 1'b1;
    end
    else if (code >= FMT_ASCII7)
    begin
      idx     = code - FMT_ASCII7;
      f.ascii = 1'b1;
      f.data7 = 1'b1;
    end
    f.stop2  = idx >= FMT_STOP2;
    f.parity = f.stop2 ? 2'(idx - FMT_STOP2) : idx[1:0];
    return f;
  endfunction

  // digits keep their low nibble; letters a..f / A..F add nine to theirs
  function automatic logic [3:0] hexNib(input logic [7:0] c);
    return c[6] ? 4'(c[3:0] + HEX_LETTER_ADJ) : c[3:0];
  endfunction
endpackage

// [hw/dssl_link.sv]
// dssl_link: RS485 serial front end of a motor drive, AHB-Lite register slave
// assumes the bus master and a user-side frame processor on the same clock
// Functional notes
// - station address register, reset 1; 0 is master, 1..247 slave; others refused
// - address 0 makes the block master: it may transmit run control at any time
// - as slave, only frames whose address equals ours are accepted, rest dropped with a frameDrop pulse
// - rate code 0..5 selects 1200..38400 bit/s, reset code 3 gives 9600
// - format 0..5: RTU, 8 data bits, none/even/odd parity, one then two stops
// - format 6..11 ASCII 7 bits, 12..17 ASCII 8 bits, same parity and stop order
// - reply held for the set delay 0..200 ms after a good frame, or until ready
// - fault code 15 when gap between good frames exceeds timeout; zero disables
// - failure action: 0 alarm and coast, 1 keep running, 2 stop without alarm
// - write reply select 1 swallows replies to write operations
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module dssl_link
  import dssl_pkg::*;
#(
  parameter int unsigned CLK_HZ_P = CLK_HZ
)
(
  input  logic        clock,
  input  logic        nrst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  input  logic        rxd,
  output logic        txd,
  output logic        txEn,
  output logic [7:0]  rxData,
  output logic        rxValid,
  output logic        frameOk,
  output logic        frameDrop,
  input  logic [7:0]  txData,
  input  logic        txValid,
  input  logic        txLast,
  input  logic        txWrite,
  output logic        txReady,
  output logic        masterRole,
  output logic        linkFault,
  output logic [7:0]  faultCode,
  output logic        coastStop,
  output logic        stopRequest,
  output logic [1:0]  stopMethod,
  output logic        irq
);
  localparam int unsigned MS_CYC    = CLK_HZ_P / MS_PER_S;
  localparam int unsigned TENTH_CYC = CLK_HZ_P / TENTHS_PER_S;
  logic [1:0]      rstSync_q;
  logic            rstN;
  logic [7:0]      stationAddr_q;
  logic [2:0]      rate_q;
  logic [4:0]      fmtSel_q;
  logic [7:0]      replyDelay_q;
  logic [9:0]      timeoutSet_q;
  logic [1:0]      failAct_q;
  logic            writeReply_q;
  logic [1:0]      stopMethod_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] stSet;
  logic            addrPhase;
  logic            statusClr;
  logic            wrPend_q;
  logic [7:0]      wrAddr_q;
  logic [31:0]     hrdata_q;
  logic [31:0]     rdMux;
  dssl_fmt_s       fmt;
  logic [15:0]     bitCyc;
  logic [3:0]      lastBit;
  logic [3:0]      charBits;
  logic [23:0]     gapCyc;
  logic [7:0]      dataMask;
  logic [2:0]      rxS_q;
  logic            rxLine_q;
  dssl_uart_e      rxSt_q;
  logic [15:0]     rxCnt_q;
  logic [3:0]      rxBit_q;
  logic [7:0]      rxSh_q;
  logic            rxPar_q;
  logic            rxBadPar_q;
  logic            rxDone_q;
  logic            rxBad_q;
  logic [7:0]      rxByte_q;
  logic [23:0]     idleCnt_q;
  logic            gapHit;
  logic            inFrame_q;
  logic            fBad_q;
  logic [1:0]      fIdx_q;
  logic [7:0]      fAddr_q;
  logic            frameOk_q;
  logic            frameDrop_q;
  logic            rxValid_q;
  logic [7:0]      rxData_q;
  logic            isStart;
  logic            endNow;
  logic            fGood;
  logic [23:0]     msCnt_q;
  logic            msTick;
  logic [7:0]      dlyCnt_q;
  logic            replyPend_q;
  logic            gateOpen_q;
  logic            txDrop;
  logic            txAccept;
  dssl_uart_e      txSt_q;
  logic [15:0]     txCnt_q;
  logic [3:0]      txBit_q;
  logic [7:0]      txSh_q;
  logic            txPar_q;
  logic            txd_q;
  logic            txEn_q;
  logic [23:0]     tenthCnt_q;
  logic            tenthTick;
  logic [9:0]      tmoCnt_q;
  logic            armed_q;
  logic            linkFault_q;
  logic            tmoEvt_q;
  logic [7:0]      faultCode_q;
  logic            coastStop_q;
  logic            stopReq_q;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // zero-wait slave: reads are sampled in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addrPhase = hsel & htrans[1] & hready;
  assign statusClr = addrPhase & ~hwrite & (haddr[7:0] == OFF_STATUS);

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h0;
    end
    else
    begin
      wrPend_q <= addrPhase & hwrite;
      if (addrPhase)
        wrAddr_q <= haddr[7:0];
      if (addrPhase & ~hwrite)
        hrdata_q <= rdMux;
    end
  end

  // out-of-range settings are refused so the link never runs undefined
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      stationAddr_q <= ADDR_RST;
      rate_q        <= RATE_RST;
      fmtSel_q      <= FMT_RST;
      replyDelay_q  <= DELAY_RST;
      timeoutSet_q  <= TMO_RST;
      failAct_q     <= ACT_ALARM;
      writeReply_q  <= 1'b0;
      stopMethod_q  <= STOPM_RST;
      mask_q        <= '0;
    end
    else if (wrPend_q)
    begin
      case (wrAddr_q)
        OFF_ADDR:    if (hwdata <= 32'(ADDR_MAX)) stationAddr_q <= hwdata[7:0];
        OFF_RATE:    if (hwdata <= 32'(RATE_MAX)) rate_q <= hwdata[2:0];
        OFF_FMT:     if (hwdata <= 32'(FMT_MAX)) fmtSel_q <= hwdata[4:0];
        OFF_DELAY:   if (hwdata <= 32'(DELAY_MAX)) replyDelay_q <= hwdata[7:0];
        OFF_TMO:     if (hwdata <= 32'(TMO_MAX)) timeoutSet_q <= hwdata[9:0];
        OFF_ACT:     if (hwdata <= 32'(ACT_STOP)) failAct_q <= hwdata[1:0];
        OFF_WRREPLY: writeReply_q <= hwdata[0];
        OFF_STOPM:   stopMethod_q <= hwdata[1:0];
        OFF_MASK:    mask_q <= hwdata[ST_W-1:0];
        default:     mask_q <= mask_q;
      endcase
    end
  end

  always_comb
  begin
    rdMux = 32'h0;
    case (haddr[7:0])
      OFF_ADDR:    rdMux[7:0] = stationAddr_q;
      OFF_RATE:    rdMux[2:0] = rate_q;
      OFF_FMT:     rdMux[4:0] = fmtSel_q;
      OFF_DELAY:   rdMux[7:0] = replyDelay_q;
      OFF_TMO:     rdMux[9:0] = timeoutSet_q;
      OFF_ACT:     rdMux[1:0] = failAct_q;
      OFF_WRREPLY: rdMux[0] = writeReply_q;
      OFF_STOPM:   rdMux[1:0] = stopMethod_q;
      OFF_STATUS:  rdMux[ST_W-1:0] = status_q;
      OFF_MASK:    rdMux[ST_W-1:0] = mask_q;
      OFF_STATE:
      begin
        rdMux[7:0]         = faultCode_q;
        rdMux[STATE_FAULT] = linkFault_q;
        rdMux[STATE_MSTR]  = masterRole;
      end
      default:     rdMux = 32'h0;
    endcase
  end

  // line format and timing follow the current settings
  assign fmt      = decodeFmt(fmtSel_q);
  assign lastBit  = fmt.data7 ? DATA7_LAST : DATA8_LAST;
  assign dataMask = fmt.data7 ? DATA7_MASK : DATA8_MASK;
  assign charBits = 4'(lastBit + FRAME_OVERHEAD + 4'(fmt.parity != PAR_NONE) + 4'(fmt.stop2));
  assign gapCyc   = 24'((32'(bitCyc) * 32'(charBits) * GAP_HALF_CHARS + 32'h1) >> 1);

  always_comb
  begin
    bitCyc = 16'(CLK_HZ_P / BAUD[RATE_RST]);
    for (int i = 0; i < 6; i++)
      if (rate_q == 3'(i))
        bitCyc = 16'(CLK_HZ_P / BAUD[i]);
  end

  // pin filter: a level change counts once the second and third stages agree
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      rxS_q    <= 3'b111;
      rxLine_q <= 1'b1;
    end
    else
    begin
      rxS_q <= {rxS_q[1:0], rxd};
      if (rxS_q[1] == rxS_q[2])
        rxLine_q <= rxS_q[2];
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      rxSt_q     <= S_IDLE;
      rxCnt_q    <= 16'h0;
      rxBit_q    <= 4'h0;
      rxSh_q     <= 8'h00;
      rxPar_q    <= 1'b0;
      rxBadPar_q <= 1'b0;
      rxDone_q   <= 1'b0;
      rxBad_q    <= 1'b0;
      rxByte_q   <= 8'h00;
    end
    else
    begin
      rxDone_q <= 1'b0;
      if (rxSt_q == S_IDLE)
      begin
        if (!rxLine_q)
        begin
          rxSt_q  <= S_START;
          rxCnt_q <= bitCyc >> 1;
        end
      end
      else if (rxCnt_q != 16'h0)
        rxCnt_q <= rxCnt_q - 16'h1;
      else
      begin
        rxCnt_q <= bitCyc - 16'h1;
        case (rxSt_q)
          S_START:
          begin
            rxSt_q     <= rxLine_q ? S_IDLE : S_DATA;
            rxBit_q    <= 4'h0;
            rxPar_q    <= 1'b0;
            rxBadPar_q <= 1'b0;
          end
          S_DATA:
          begin
            rxSh_q  <= {rxLine_q, rxSh_q[7:1]};
            rxPar_q <= rxPar_q ^ rxLine_q;
            rxBit_q <= rxBit_q + 4'h1;
            if (rxBit_q == lastBit)
              rxSt_q <= (fmt.parity == PAR_NONE) ? S_STOP : S_PAR;
          end
          S_PAR:
          begin
            rxBadPar_q <= (rxPar_q ^ rxLine_q) != (fmt.parity == PAR_ODD);
            rxSt_q     <= S_STOP;
          end
          S_STOP:
          begin
            rxSt_q   <= S_IDLE;
            rxDone_q <= 1'b1;
            rxBad_q  <= rxBadPar_q | ~rxLine_q;
            rxByte_q <= fmt.data7 ? {1'b0, rxSh_q[7:1]} : rxSh_q;
          end
          default: rxSt_q <= S_IDLE;
        endcase
      end
    end
  end

  // gap is timed from the middle of the first stop bit, a half bit early with one stop bit, one and a half with two
  assign gapHit = (rxSt_q == S_IDLE) && (idleCnt_q == gapCyc - 24'h1);

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      idleCnt_q <= 24'h0;
    else if (rxSt_q != S_IDLE)
      idleCnt_q <= 24'h0;
    else if (idleCnt_q != gapCyc)
      idleCnt_q <= idleCnt_q + 24'h1;
  end

  assign masterRole = stationAddr_q == ADDR_MASTER;
  assign isStart    = rxDone_q & fmt.ascii & ~rxBad_q & (rxByte_q == ASCII_START);
  assign endNow     = inFrame_q & (fmt.ascii ? rxDone_q & (rxByte_q == ASCII_END) : gapHit);
  assign fGood      = ~(fBad_q | (rxDone_q & rxBad_q))
                    & (masterRole | (fAddr_q == stationAddr_q));

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      inFrame_q   <= 1'b0;
      fBad_q      <= 1'b0;
      fIdx_q      <= FIDX_HI;
      fAddr_q     <= 8'h00;
      frameOk_q   <= 1'b0;
      frameDrop_q <= 1'b0;
      rxValid_q   <= 1'b0;
      rxData_q    <= 8'h00;
    end
    else
    begin
      rxValid_q   <= 1'b0;
      frameOk_q   <= 1'b0;
      frameDrop_q <= 1'b0;
      if (rxDone_q)
        rxData_q <= rxByte_q;
      if (isStart)
      begin
        inFrame_q <= 1'b1;
        fBad_q    <= 1'b0;
        fIdx_q    <= FIDX_HI;
        rxValid_q <= 1'b1;
      end
      else if (endNow)
      begin
        inFrame_q   <= 1'b0;
        frameOk_q   <= fGood;
        frameDrop_q <= ~fGood;
        rxValid_q   <= fmt.ascii;
      end
      else if (rxDone_q & (inFrame_q | ~fmt.ascii))
      begin
        rxValid_q <= 1'b1;
        inFrame_q <= 1'b1;
        fBad_q    <= (inFrame_q & fBad_q) | rxBad_q;
        if (!inFrame_q)
          fAddr_q <= rxByte_q;
        else if (fmt.ascii && fIdx_q != FIDX_DONE)
        begin
          fIdx_q <= fIdx_q + 2'h1;
          if (fIdx_q == FIDX_HI)
            fAddr_q[7:4] <= hexNib(rxByte_q);
          else
            fAddr_q[3:0] <= hexNib(rxByte_q);
        end
      end
    end
  end

  // ms base restarts at each good frame so the reply delay is exact
  assign msTick = msCnt_q == 24'(MS_CYC - 1);

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      msCnt_q <= 24'h0;
    else if (frameOk_q | msTick)
      msCnt_q <= 24'h0;
    else
      msCnt_q <= msCnt_q + 24'h1;
  end

  // gate stays open until the user supplies the reply, covering slow processing
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      replyPend_q <= 1'b0;
      gateOpen_q  <= 1'b0;
      dlyCnt_q    <= 8'h00;
    end
    else if (frameOk_q & ~masterRole)
    begin
      replyPend_q <= 1'b1;
      gateOpen_q  <= 1'b0;
      dlyCnt_q    <= replyDelay_q;
    end
    else if (replyPend_q)
    begin
      if (dlyCnt_q == 8'h00)
      begin
        replyPend_q <= 1'b0;
        gateOpen_q  <= 1'b1;
      end
      else if (msTick)
        dlyCnt_q <= dlyCnt_q - 8'h01;
    end
    else if (txAccept & txLast)
      gateOpen_q <= 1'b0;
  end

  assign txDrop   = txWrite & writeReply_q;
  assign txReady  = (masterRole | gateOpen_q) & (txSt_q == S_IDLE);
  assign txAccept = txValid & txReady;
  assign txd      = txd_q;
  assign txEn     = txEn_q;

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      txSt_q  <= S_IDLE;
      txCnt_q <= 16'h0;
      txBit_q <= 4'h0;
      txSh_q  <= 8'h00;
      txPar_q <= 1'b0;
      txd_q   <= 1'b1;
      txEn_q  <= 1'b0;
    end
    else if (txSt_q == S_IDLE)
    begin
      txd_q  <= ~(txAccept & ~txDrop);
      txEn_q <= txAccept & ~txDrop;
      if (txAccept & ~txDrop)
      begin
        txSt_q  <= S_START;
        txCnt_q <= bitCyc - 16'h1;
        txBit_q <= 4'h0;
        txSh_q  <= txData;
        txPar_q <= (^(txData & dataMask)) ^ (fmt.parity == PAR_ODD);
      end
    end
    else if (txCnt_q != 16'h0)
      txCnt_q <= txCnt_q - 16'h1;
    else
    begin
      txCnt_q <= bitCyc - 16'h1;
      case (txSt_q)
        S_START:
        begin
          txSt_q <= S_DATA;
          txd_q  <= txSh_q[0];
          txSh_q <= txSh_q >> 1;
        end
        S_DATA:
          if (txBit_q == lastBit)
          begin
            txSt_q  <= (fmt.parity == PAR_NONE) ? S_STOP : S_PAR;
            txd_q   <= (fmt.parity == PAR_NONE) | txPar_q;
            txBit_q <= 4'h0;
          end
          else
          begin
            txBit_q <= txBit_q + 4'h1;
            txd_q   <= txSh_q[0];
            txSh_q  <= txSh_q >> 1;
          end
        S_PAR:
        begin
          txSt_q <= S_STOP;
          txd_q  <= 1'b1;
        end
        S_STOP:
          if (fmt.stop2 && txBit_q == 4'h0)
            txBit_q <= 4'h1;
          else
          begin
            txSt_q <= S_IDLE;
            txEn_q <= 1'b0;
          end
        default: txSt_q <= S_IDLE;
      endcase
    end
  end

  // timeout is armed by the first good frame so a silent bus after power-up is no fault
  assign tenthTick = tenthCnt_q == 24'(TENTH_CYC - 1);

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      tenthCnt_q <= 24'h0;
    else if (frameOk_q | tenthTick)
      tenthCnt_q <= 24'h0;
    else
      tenthCnt_q <= tenthCnt_q + 24'h1;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      tmoCnt_q    <= 10'h000;
      armed_q     <= 1'b0;
      linkFault_q <= 1'b0;
      tmoEvt_q    <= 1'b0;
      faultCode_q <= 8'h00;
      coastStop_q <= 1'b0;
      stopReq_q   <= 1'b0;
    end
    else
    begin
      tmoEvt_q <= 1'b0;
      if (frameOk_q)
      begin
        armed_q     <= 1'b1;
        tmoCnt_q    <= 10'h000;
        linkFault_q <= 1'b0;
      end
      else
      begin
        if (tenthTick && tmoCnt_q != TMO_MAX)
          tmoCnt_q <= tmoCnt_q + 10'h001;
        if (armed_q && timeoutSet_q != TMO_RST && tmoCnt_q >= timeoutSet_q && !linkFault_q)
        begin
          linkFault_q <= 1'b1;
          tmoEvt_q    <= 1'b1;
        end
      end
      faultCode_q <= (linkFault_q && !frameOk_q && failAct_q == ACT_ALARM) ? FAULT_CODE : 8'h00;
      coastStop_q <= linkFault_q && !frameOk_q && failAct_q == ACT_ALARM;
      stopReq_q   <= linkFault_q && !frameOk_q && failAct_q == ACT_STOP;
    end
  end

  // a new event in the clearing read's cycle survives
  assign stSet = {tmoEvt_q, frameDrop_q, frameOk_q};

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      status_q <= '0;
    else
      status_q <= (status_q & ~{ST_W{statusClr}}) | stSet;
  end

  assign irq         = |(status_q & mask_q);
  assign rxData      = rxData_q;
  assign rxValid     = rxValid_q;
  assign frameOk     = frameOk_q;
  assign frameDrop   = frameDrop_q;
  assign linkFault   = linkFault_q;
  assign faultCode   = faultCode_q;
  assign coastStop   = coastStop_q;
  assign stopRequest = stopReq_q;
  assign stopMethod  = stopMethod_q;
endmodule // dssl_link

// [verification/dssl_host_model.sv]
// dssl_host_model: host station on the RS485 pair
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/1ps
module dssl_host_model
(
  input  wire logic clock,
  input  wire logic txd,
  output logic      rxd
);
  // idle line sits high between characters
  initial rxd = 1'b1;
  // caller matches device rate and format; bad flips the parity bit
  task automatic putc(input logic [7:0] c, input int bc, nb, input logic [1:0] p, input bit s2, bad);
    logic pb;
    pb = ^(c & 8'((1 << nb) - 1)) ^ p[1] ^ bad;
    rxd <= 1'b0;
    repeat (bc) @(posedge clock);
    for (int i = 0; i < nb; i++)
    begin
      rxd <= c[i];
      repeat (bc) @(posedge clock);
    end
    if (p != 2'h0)
    begin
      rxd <= pb;
      repeat (bc) @(posedge clock);
    end
    rxd <= 1'b1;
    repeat (s2 ? 2 * bc : bc) @(posedge clock);
  endtask
  task automatic getc(input int bc, output logic [7:0] c);
    @(negedge txd);
    repeat (bc + bc / 2) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      c[i] = txd;
      repeat (bc) @(posedge clock);
    end
  endtask
endmodule // dssl_host_model

// [verification/dssl_link_monitor.sv]
// dssl_link_monitor: port assertions for dssl_link
// assumes bind into dssl_link; sees its ports only
`timescale 1ns/1ps
module dssl_link_monitor
  import dssl_pkg::*;
(
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       txd,
  input wire logic       txEn,
  input wire logic       txReady,
  input wire logic       frameOk,
  input wire logic       frameDrop,
  input wire logic       linkFault,
  input wire logic [7:0] faultCode,
  input wire logic       coastStop,
  input wire logic       stopRequest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  frame_excl_a: assert property (!(frameOk && frameDrop))
    else $error("ok and drop together");
  ok_pulse_a: assert property (frameOk |=> !frameOk)
    else $error("ok pulse too long");
  tx_idle_a: assert property (!txEn |-> txd)
    else $error("txd low while off");
  start_bit_a: assert property ($rose(txEn) |-> (txEn && !txd)[*4])
    else $error("start bit short");
  busy_ready_a: assert property (txEn |-> !txReady)
    else $error("ready while sending");
  coast_code_a: assert property (coastStop |-> linkFault && faultCode == FAULT_CODE)
    else $error("coast without code");
  code_zero_a: assert property (!coastStop |-> faultCode == 8'h00)
    else $error("code without coast");
  stop_excl_a: assert property (stopRequest |-> linkFault && !coastStop)
    else $error("bad stop request");
  ok_c: cover property (frameOk);
  drop_c: cover property (frameDrop);
  coast_c: cover property (coastStop);
  stop_c: cover property (stopRequest);
endmodule // dssl_link_monitor
bind dssl_link dssl_link_monitor mon_u (.clock(clock), .nrst(nrst), .txd(txd), .txEn(txEn),
  .txReady(txReady), .frameOk(frameOk), .frameDrop(frameDrop), .linkFault(linkFault),
  .faultCode(faultCode), .coastStop(coastStop), .stopRequest(stopRequest));

// [verification/tb_top.sv]
// tb_top: random and corner tests of dssl_link with a host model
// assumes CLK_HZ_P of 100 kHz: 1 ms is 100 cycles, 0.1 s is 10000
`timescale 1ns/1ps
module tb_top
  import dssl_pkg::*;
;
  localparam int HZ = 100000;
  logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, txValid = 0, txLast = 1, txWrite = 0;
  logic [1:0] htrans = 0, stopMethod;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic hready, hresp, rxd, txd, txEn, rxValid, frameOk, frameDrop, txReady, masterRole;
  logic linkFault, coastStop, stopRequest, irq;
  logic [7:0] txData = 0, rxData, faultCode, rb, own, lastRx;
  int err_total = 0, compares = 0, cyc = 0, nOk = 0, nDrop = 0, nTx = 0, tOk = 0, tAcc = 0;
  int unsigned rstVal [12] = '{1, 3, 0, 5, 0, 0, 0, 0, 0, 0, 0, 0};
  always #12.5 clock = ~clock;
  dssl_link #(.CLK_HZ_P(HZ)) dut_u (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd), .txEn(txEn),
    .rxData(rxData), .rxValid(rxValid), .frameOk(frameOk), .frameDrop(frameDrop),
    .txData(txData), .txValid(txValid), .txLast(txLast), .txWrite(txWrite),
    .txReady(txReady), .masterRole(masterRole), .linkFault(linkFault),
    .faultCode(faultCode), .coastStop(coastStop), .stopRequest(stopRequest),
    .stopMethod(stopMethod), .irq(irq));
  dssl_host_model host_u (.clock(clock), .txd(txd), .rxd(rxd));
  task automatic test_done;
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // pulses are counted at the falling edge, clear of the launching edge
  always @(negedge clock)
  begin
    cyc <= cyc + 1;
    nOk <= nOk + (frameOk === 1'b1);
    nDrop <= nDrop + (frameDrop === 1'b1);
    nTx <= nTx + (txEn === 1'b1);
    lastRx <= (rxValid === 1'b1) ? rxData : lastRx;
    if (frameOk === 1'b1)
      tOk <= cyc;
    if (cyc == 100000)
    begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 10) ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic frm(input int f, r, input logic [7:0] a, input bit bad, ok);
    int bc, ix, o, d;
    logic [7:0] c [$];
    logic [7:0] v;
    bc = HZ / BAUD[r];
    ix = (f < 6) ? f : (f - 6) % 6;
    v = 8'($urandom) & 8'h7f;
    o = nOk;
    d = nDrop;
    wr(OFF_RATE, r);
    wr(OFF_FMT, f);
    if (f < 6)
      c = '{a, v};
    else
      c = '{8'h3a, hx(a[7:4]), hx(a[3:0]), hx(v[7:4]), hx(v[3:0]), 8'h0d, 8'h0a};
    foreach (c[i])
      host_u.putc(c[i], bc, (f > 5 && f < 12) ? 7 : 8, 2'(ix % 3), ix > 2, bad && i == 1);
    // gap well above three and a half characters closes an RTU frame
    repeat (50 * bc) @(posedge clock);
    chk(nOk - o, ok);
    chk(nDrop - d, !ok);
    chk(lastRx, (f < 6) ? v : 8'h0a);
  endtask
  task automatic reply(input logic w);
    txData <= 8'($urandom);
    txWrite <= w;
    txValid <= 1'b1;
    fork
      frm(0, 3, own, 0, 1);
      begin
        do @(negedge clock); while (txReady !== 1'b1);
        @(posedge clock);
        txValid <= 1'b0;
        tAcc = cyc;
      end
    join
  endtask
  initial
  begin
    logic [31:0] q;
    void'($urandom(32'hb4bfd39c));
    own = 8'($urandom_range(247, 1));
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rstVal[i]) rd(8'(i * 4), rstVal[i]);
    wr(OFF_ADDR, 248);
    wr(OFF_RATE, 6);
    wr(OFF_FMT, 18);
    rd(OFF_ADDR, 1);
    rd(OFF_RATE, 3);
    rd(OFF_FMT, 0);
    wr(OFF_ADDR, own);
    wr(OFF_DELAY, 1);
    wr(OFF_MASK, 3);
    fork
      reply(0);
      host_u.getc(HZ / 9600, rb);
    join
    chk(32'(tAcc - tOk - HZ / 1000 + 1) < 6, 1);
    chk(rb, txData);
    wr(OFF_WRREPLY, 1);
    wait (txEn === 1'b0);
    q = nTx;
    reply(1);
    chk(nTx - q, 0);
    chk(irq, 1);
    rd(OFF_STATUS, 1);
    chk(irq, 0);
    for (int f = 0; f < 18; f++)
    begin
      logic [7:0] a;
      bit bad;
      a = ($urandom % 2) ? own : own ^ 8'h80;
      bad = (f % 3 != 0) && (f == 1 || $urandom % 3 == 0);
      frm(f, (f < 5) ? f : 2 + f % 2, a, bad, a == own && !bad);
    end
    wr(OFF_ADDR, 0);
    wr(OFF_STOPM, 2);
    rd(OFF_STATE, 32'h200);
    chk({masterRole, stopMethod}, 3'h6);
    frm(0, 3, own ^ 8'h80, 0, 1);
    txWrite <= 1'b0;
    txValid <= 1'b1;
    @(negedge clock);
    chk(txReady, 1);
    @(posedge clock);
    txValid <= 1'b0;
    wr(OFF_ADDR, own);
    wr(OFF_TMO, 1);
    wr(OFF_MASK, 4);
    bus(OFF_STATUS, 1'b0, 32'h0, q);
    for (int a = 0; a < 3; a++)
    begin
      wr(OFF_ACT, a);
      frm(0, 3, own, 0, 1);
      chk(linkFault, 0);
      repeat (HZ / 10 - 700) @(posedge clock);
      chk(linkFault, 0);
      repeat (800) @(posedge clock);
      chk({linkFault, coastStop, stopRequest, faultCode}, {a < 3, a == 0, a == 2, a ? 8'h00 : 8'h0f});
      chk(irq, 1);
      rd(OFF_STATUS, 5);
    end
    test_done();
  end
endmodule // tb_top
